// ===== plb_pkg.sv
// Purpose: Shared constants, register map and types for the logic block.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Term and macrocell words are static once the run bit is set.
package plb_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Array dimensions.
    localparam int NUM_IN   = 36;
    localparam int NUM_MC   = 16;
    localparam int NUM_PT   = 48;
    localparam int NUM_CTL  = 8;
    localparam int NUM_FB   = 8;
    localparam int NUM_GCK  = 4;
    localparam int NUM_SRC  = 8;
    localparam int CTL_BASE = 32;
    localparam int CLKT_OFS = 4;
    localparam int FB_BASE  = 40;
    localparam int SHR_BASE = 16;
    localparam int NUM_SHR  = NUM_PT - SHR_BASE;
    localparam int ADDR_W   = 12;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses).
    localparam logic [ADDR_W-1:0] PT_BASE  = 12'h000;
    localparam logic [ADDR_W-1:0] MC_BASE  = 12'h400;
    localparam logic [ADDR_W-1:0] GLB_ADDR = 12'h600;
    localparam logic [ADDR_W-1:0] STM_ADDR = 12'h604;
    localparam logic [ADDR_W-1:0] STP_ADDR = 12'h608;

    // Word positions inside a product term slot and bit fields of its high word.
    localparam logic [1:0] PT_W_TRUE = 2'h0;
    localparam logic [1:0] PT_W_COMP = 2'h1;
    localparam logic [1:0] PT_W_HI   = 2'h2;
    localparam int         PT_HI_W   = 17;
    localparam int         PT_HI_TC  = 4;
    localparam int         PT_HI_FB  = 8;
    localparam int         PT_HI_OR  = 16;

    ////////////////////////////////////////////////////////////////////////
    // Storage modes, Gray ordered D, T, latch, combinational.
    typedef enum logic [1:0] {
        MODE_D    = 2'h0,
        MODE_T    = 2'h1,
        MODE_LAT  = 2'h3,
        MODE_COMB = 2'h2
    } plb_mode_t;

    // Clock sources offered to each macrocell register.
    typedef enum logic [2:0] {
        CLK_G0 = 3'h0, CLK_G1 = 3'h1, CLK_UNIV = 3'h2, CLK_PT = 3'h3,
        CLK_T4 = 3'h4, CLK_T5 = 3'h5, CLK_T6 = 3'h6, CLK_T7 = 3'h7
    } plb_clk_t;

    // Output enable modes of the I/O cell.
    typedef enum logic [2:0] {
        OE_WEAK_PULLUP = 3'h0, OE_ON = 3'h1, OE_OFF = 3'h2, OE_CTL = 3'h3,
        OE_NCTL = 3'h4, OE_GOE = 3'h5, OE_NGOE = 3'h6, OE_PT = 3'h7
    } plb_oe_t;

    // Macrocell configuration word 0.
    typedef struct packed {
        logic [5:0] pad;
        logic [2:0] oe_ctl;
        logic [3:0] fn_tt;
        logic       in_reg;
        logic       slew;
        plb_oe_t    oe_mode;
        logic [2:0] pre_ctl;
        logic       pre_en;
        logic [2:0] rst_ctl;
        logic       rst_en;
        logic       init;
        plb_clk_t   clk_sel;
        plb_mode_t  mode;
    } plb_mc_cfg_t;

    // One product term's literal selection.
    typedef struct packed {
        logic              or_mode;
        logic [NUM_FB-1:0] fb_m;
        logic [NUM_IN-1:0] comp_m;
        logic [NUM_IN-1:0] true_m;
    } plb_pt_cfg_t;

    // Global control word.
    typedef struct packed {
        logic       run;
        logic [1:0] gsel1;
        logic [1:0] gsel0;
    } plb_glb_t;

    // Drive of one I/O pad.
    typedef struct packed {
        logic out;
        logic oe;
        logic pull;
        logic slow;
    } plb_pad_t;

    localparam plb_mc_cfg_t MC_CFG_RST = 32'h0000_0000;
    localparam plb_glb_t    GLB_RST    = 5'h00;

endpackage : plb_pkg

// ===== plb_pterm.sv
// Purpose: One product term of the shared array.
// Assumes: Literal masks are static while the block runs.
// Notes:   An empty mask in AND form yields a constant one.
`timescale 1ns/1ps
module plb_pterm (
    // Literals.
    input  wire logic                        i_fold_sel_unused_n,
    input  wire logic [plb_pkg::NUM_IN-1:0]  i_xpt,
    input  wire logic [plb_pkg::NUM_FB-1:0]  i_fb,
    // Configuration.
    input  wire plb_pkg::plb_pt_cfg_t        i_cfg,
    // Result.
    output logic                             o_term
);
    import plb_pkg::*;

    logic and_v;
    logic or_v;

    // True and complement literals, plus folded-back inverted terms.
    always_comb begin
        and_v = (&(~i_cfg.true_m | i_xpt)) & (&(~i_cfg.comp_m | ~i_xpt))
              & (&(~i_cfg.fb_m | i_fb)) & i_fold_sel_unused_n;
        or_v  = |((i_cfg.true_m & i_xpt) | (i_cfg.comp_m & ~i_xpt));
        o_term = i_cfg.or_mode ? or_v : and_v;
    end

endmodule : plb_pterm

// ===== plb_mcell.sv
// Purpose: One macrocell with its storage element and I/O cell.
// Assumes: Source clocks are levels sampled by the system clock.
// Notes:   Register edges lag the source edge by one system cycle.
`timescale 1ns/1ps
module plb_mcell (
    // Clock and reset.
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_rst_n,
    input  wire logic                        i_run,
    // Configuration.
    input  wire plb_pkg::plb_mc_cfg_t        i_cfg,
    // Logic inputs.
    input  wire logic                        i_pt,
    input  wire logic                        i_or,
    input  wire logic                        i_pin,
    input  wire logic                        i_goe,
    input  wire logic [plb_pkg::NUM_SRC-1:0] i_clk_src,
    input  wire logic [plb_pkg::NUM_CTL-1:0] i_ctl,
    // Results.
    output logic                             o_q,
    output plb_pkg::plb_pad_t                o_pad
);
    import plb_pkg::*;

    logic src;
    logic src_prev_q;
    logic rise;
    logic d_fn;
    logic d_in;
    logic q_q;

    // Clock pick, two-input function and the fast pin path.
    always_comb begin
        src  = i_clk_src[i_cfg.clk_sel];
        rise = src & ~src_prev_q;
        d_fn = i_cfg.fn_tt[{i_pt, i_or}];
        d_in = i_cfg.in_reg ? i_pin : d_fn;
    end

    // Edge history of the chosen clock source.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            src_prev_q <= 1'b0;
        end else begin
            src_prev_q <= src;
        end
    end

    // Storage element; reset beats preset, both beat the clock.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q_q <= 1'b0;
        end else if (!i_run) begin
            q_q <= i_cfg.init;
        end else if (i_cfg.rst_en && i_ctl[i_cfg.rst_ctl]) begin
            q_q <= 1'b0;
        end else if (i_cfg.pre_en && i_ctl[i_cfg.pre_ctl]) begin
            q_q <= 1'b1;
        end else begin
            case (i_cfg.mode)
                MODE_D: begin
                    if (rise) q_q <= d_in;
                end
                MODE_T: begin
                    if (rise) q_q <= q_q ^ d_in;
                end
                MODE_LAT: begin
                    if (src) q_q <= d_in;
                end
                MODE_COMB: begin
                    q_q <= d_in;
                end
                default: begin
                    q_q <= q_q;
                end
            endcase
        end
    end

    // I/O cell drive; an idle block leaves every pin pulled up.
    always_comb begin
        o_q        = q_q;
        o_pad.out  = q_q;
        o_pad.slow = i_cfg.slew;
        o_pad.pull = 1'b0;
        o_pad.oe   = 1'b0;
        case (i_cfg.oe_mode)
            OE_WEAK_PULLUP: o_pad.pull = 1'b1;
            OE_ON:          o_pad.oe   = 1'b1;
            OE_OFF:         o_pad.oe   = 1'b0;
            OE_CTL:         o_pad.oe   = i_ctl[i_cfg.oe_ctl];
            OE_NCTL:        o_pad.oe   = ~i_ctl[i_cfg.oe_ctl];
            OE_GOE:         o_pad.oe   = i_goe;
            OE_NGOE:        o_pad.oe   = ~i_goe;
            OE_PT:          o_pad.oe   = i_pt;
            default:        o_pad.oe   = 1'b0;
        endcase
        if (!i_run) begin
            o_pad.oe   = 1'b0;
            o_pad.pull = 1'b1;
        end
    end

endmodule : plb_mcell

// ===== plb_logic_block.sv
// Purpose: One programmable logic block: term array, control terms,
//          sixteen macrocells and their I/O cells, set up over APB.
// Assumes: All link inputs are synchronous to i_sys_clk.
// Notes:   Term and macrocell writes are refused while the run bit is set.
//
// Overview of operation
// - 36 crosspoint inputs, sixteen macrocells per block.
// - 48 terms from true, complement inputs.
// - Eight terms serve as local control terms.
// - Eight inverted fold-back terms feed other terms.
// - Term plus OR feed two-input function.
// - Extra terms drawn from the shared pool.
// - Storage is D, toggle, latch or none.
// - Register clock picked from eight sources.
// - Two global clocks from four pins, universal.
// - Clock terms selectable AND or OR form.
// - Register starts at configured one or zero.
// - Independent preset and reset per macrocell.
// - Macrocell result fed back; output enabled.
// - Input pin undriven, level fed back.
// - Buried result returns even when pin inputs.
// - Direct pin to register capture path.
// - Eight output enable modes, one weak pull-up.
// - One slew control bit per output.
`timescale 1ns/1ps
module plb_logic_block (
    // Clock and reset.
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_rst_n,

    // APB register port.
    input  wire logic                        i_psel,
    input  wire logic                        i_penable,
    input  wire logic                        i_pwrite,
    input  wire logic [plb_pkg::ADDR_W-1:0]  i_paddr,
    input  wire logic [31:0]                 i_pwdata,
    output logic      [31:0]                 o_prdata,
    output logic                             o_pready,
    output logic                             o_pslverr,

    // Crosspoint inputs and clock pins.
    input  wire logic [plb_pkg::NUM_IN-1:0]  i_xpt,
    input  wire logic [plb_pkg::NUM_GCK-1:0] i_clk_pin,
    input  wire logic                        i_uclk,
    input  wire logic                        i_goe,

    // Pads.
    input  wire logic [plb_pkg::NUM_MC-1:0]  i_pin_in,
    output logic      [plb_pkg::NUM_MC-1:0]  o_pin_out,
    output logic      [plb_pkg::NUM_MC-1:0]  o_pin_oe,
    output logic      [plb_pkg::NUM_MC-1:0]  o_pin_pullup,
    output logic      [plb_pkg::NUM_MC-1:0]  o_pin_slow,

    // Feedback to the crosspoint array.
    output logic      [plb_pkg::NUM_MC-1:0]  o_mc_fb,
    output logic      [plb_pkg::NUM_MC-1:0]  o_io_fb
);
    import plb_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Configuration storage.

    logic [31:0]        pt_true_q [NUM_PT];
    logic [31:0]        pt_comp_q [NUM_PT];
    logic [PT_HI_W-1:0] pt_hi_q   [NUM_PT];

    plb_mc_cfg_t        mc_cfg_q  [NUM_MC];
    logic [NUM_SHR-1:0] mc_alloc_q[NUM_MC];

    plb_glb_t           glb_q;

    ////////////////////////////////////////////////////////////////////////
    // Address decode.

    logic [5:0]  pt_idx;
    logic [1:0]  pt_word;
    logic [3:0]  mc_idx;
    logic        mc_word;

    logic        pt_hit;
    logic        mc_hit;
    logic        glb_hit;
    logic        stm_hit;
    logic        stp_hit;
    logic        acc_err;

    logic        setup_go;
    logic        wr_ok;

    logic [31:0] rdata;

    // Region decode; misaligned or unlisted addresses answer with an error.
    always_comb begin
        // A term slot is 16 bytes, a cell 8.
        pt_idx  = i_paddr[9:4];
        pt_word = i_paddr[3:2];
        mc_idx  = i_paddr[6:3];
        mc_word = i_paddr[2];
        pt_hit  = (i_paddr[11:10] == PT_BASE[11:10]) && (pt_word != 2'h3)
                  && (pt_idx < 6'(NUM_PT)) && (i_paddr[1:0] == 2'h0);
        mc_hit  = (i_paddr[11:9] == MC_BASE[11:9]) && (i_paddr[8:7] == 2'h0)
                  && (i_paddr[1:0] == 2'h0);
        glb_hit = (i_paddr == GLB_ADDR);
        stm_hit = (i_paddr == STM_ADDR);
        stp_hit = (i_paddr == STP_ADDR);
        acc_err = !(pt_hit || mc_hit || glb_hit
                    || ((stm_hit || stp_hit) && !i_pwrite))
                  || (i_pwrite && (pt_hit || mc_hit) && glb_q.run);
    end

    // Read data mux, evaluated on the first access cycle.
    always_comb begin
        rdata = 32'h0000_0000;
        if (pt_hit) begin
            case (pt_word)
                PT_W_TRUE: begin
                    rdata = pt_true_q[pt_idx];
                end
                PT_W_COMP: begin
                    rdata = pt_comp_q[pt_idx];
                end
                default: begin
                    rdata = {15'h0000, pt_hi_q[pt_idx]};
                end
            endcase
        end else if (mc_hit) begin
            if (mc_word) begin
                rdata = mc_alloc_q[mc_idx];
            end else begin
                rdata = mc_cfg_q[mc_idx];
            end
        end else if (glb_hit) begin
            rdata = {27'h000_0000, glb_q};
        end else if (stm_hit) begin
            rdata = {16'h0000, o_mc_fb};
        end else if (stp_hit) begin
            rdata = {16'h0000, o_io_fb};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, then the answer from flip-flops.

    // The wait state lets the answer come straight from registers.
    always_comb begin
        setup_go = i_psel && i_penable && !o_pready;
        wr_ok    = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;
    end

    // Handshake flags.
    // An error only ever comes with ready.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= setup_go;
            o_pslverr <= setup_go && acc_err;
        end
    end

    // Read data holds until the next transfer is set up.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0000_0000;
        end else if (setup_go) begin
            if (acc_err || i_pwrite) begin
                o_prdata <= 32'h0000_0000;
            end else begin
                o_prdata <= rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration writes.

    // Product term masks; refused while running, so the array stays static.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int t = 0; t < NUM_PT; t++) begin
                pt_true_q[t] <= 32'h0000_0000;
                pt_comp_q[t] <= 32'h0000_0000;
                pt_hi_q[t]   <= 17'h0_0000;
            end
        end else if (wr_ok && pt_hit) begin
            case (pt_word)
                PT_W_TRUE: begin
                    pt_true_q[pt_idx] <= i_pwdata;
                end
                PT_W_COMP: begin
                    pt_comp_q[pt_idx] <= i_pwdata;
                end
                default: begin
                    pt_hi_q[pt_idx] <= i_pwdata[PT_HI_W-1:0];
                end
            endcase
        end
    end

    // Macrocell words.
    // Word 1 picks shared terms to OR in.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int m = 0; m < NUM_MC; m++) begin
                mc_cfg_q[m]   <= MC_CFG_RST;
                mc_alloc_q[m] <= 32'h0000_0000;
            end
        end else if (wr_ok && mc_hit) begin
            if (mc_word) begin
                mc_alloc_q[mc_idx] <= i_pwdata;
            end else begin
                mc_cfg_q[mc_idx] <= i_pwdata;
            end
        end
    end

    // Global word; always writable so software can stop and restart.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            glb_q <= GLB_RST;
        end else if (wr_ok && glb_hit) begin
            glb_q <= i_pwdata[4:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Product term array.

    logic [NUM_PT-1:0]  term;
    logic [NUM_FB-1:0]  fold;
    logic [NUM_CTL-1:0] ctl;

    logic [1:0]         gclk;

    // Fold-back terms are inverted before reuse.
    assign fold = ~term[FB_BASE +: NUM_FB];

    // Local control terms are a fixed slice of the array.
    assign ctl  = term[CTL_BASE +: NUM_CTL];

    for (genvar t = 0; t < NUM_PT; t++) begin : g_pt
        plb_pt_cfg_t cfg;

        // Fold-back terms take no fold-back input, which keeps the array
        // free of combinational loops.
        always_comb begin
            cfg.true_m  = {pt_hi_q[t][PT_HI_TC-1:0], pt_true_q[t]};
            cfg.comp_m  = {pt_hi_q[t][PT_HI_FB-1:PT_HI_TC], pt_comp_q[t]};
            cfg.fb_m    = (t >= FB_BASE) ? 8'h00
                          : pt_hi_q[t][PT_HI_OR-1:PT_HI_FB];
            cfg.or_mode = (t >= CTL_BASE + CLKT_OFS) && (t < FB_BASE)
                          && pt_hi_q[t][PT_HI_OR];
        end

        // One AND or OR term per slot.
        plb_pterm u_pterm (
            .i_fold_sel_unused_n (1'b1),
            .i_xpt               (i_xpt),
            .i_fb                ((t >= FB_BASE) ? 8'hff : fold),
            .i_cfg               (cfg),
            .o_term              (term[t])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock sources.

    // Two global clocks, each picked from the four clock pins.
    always_comb begin
        gclk[0] = i_clk_pin[glb_q.gsel0];
        gclk[1] = i_clk_pin[glb_q.gsel1];
    end

    ////////////////////////////////////////////////////////////////////////
    // Macrocells.

    plb_pad_t          pad  [NUM_MC];
    logic [NUM_MC-1:0] mc_q;

    for (genvar m = 0; m < NUM_MC; m++) begin : g_mc
        logic               shr_or;
        logic [NUM_SRC-1:0] srcs;

        // Extra terms come from the shared slice of the array.
        assign shr_or = |(term[SHR_BASE +: NUM_SHR] & mc_alloc_q[m]);

        // Eight clock sources: globals, universal, own term, clock terms.
        assign srcs   = {ctl[NUM_CTL-1:CLKT_OFS], term[m], i_uclk, gclk};

        // Term m is cell m's own input.
        plb_mcell u_mcell (
            .i_sys_clk (i_sys_clk),
            .i_rst_n   (i_rst_n),
            .i_run     (glb_q.run),
            .i_cfg     (mc_cfg_q[m]),
            .i_pt      (term[m]),
            .i_or      (shr_or),
            .i_pin     (i_pin_in[m]),
            .i_goe     (i_goe),
            .i_clk_src (srcs),
            .i_ctl     (ctl),
            .o_q       (mc_q[m]),
            .o_pad     (pad[m])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Output registers.

    // Pad drive registered so every port comes from a flip-flop.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pin_out    <= 16'h0000;
            o_pin_oe     <= 16'h0000;
            o_pin_pullup <= 16'hffff;
            o_pin_slow   <= 16'h0000;
        end else begin
            for (int m = 0; m < NUM_MC; m++) begin
                o_pin_out[m]    <= pad[m].out;
                o_pin_oe[m]     <= pad[m].oe;
                o_pin_pullup[m] <= pad[m].pull;
                o_pin_slow[m]   <= pad[m].slow;
            end
        end
    end

    // Two feedback paths: the buried result returns whatever the pin does.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mc_fb <= 16'h0000;
            o_io_fb <= 16'h0000;
        end else begin
            o_mc_fb <= mc_q;
            o_io_fb <= i_pin_in;
        end
    end

endmodule : plb_logic_block

// ===== plb_asserts.sv
// Purpose: Port checks of the logic block.
// Assumes: Bound into every plb_logic_block.
// Notes:   Sees the top-level ports only.
`timescale 1ns/1ps
module plb_asserts (
    // Clock and reset.
    input wire logic        i_sys_clk,
    input wire logic        i_rst_n,
    // APB.
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    // Pads and feedback.
    input wire logic [15:0] i_pin_in,
    input wire logic [15:0] o_pin_oe,
    input wire logic [15:0] o_pin_pullup,
    input wire logic [15:0] o_mc_fb,
    input wire logic [15:0] o_io_fb
);
    // One clock domain, so checks rest while reset is low.
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////
    property p_rdy_one; o_pready |=> !o_pready; endproperty
    a_rdy_one: assert property (p_rdy_one)
        else $error("pready stayed high");
    property p_rdy_lat; i_psel && i_penable && !$past(i_penable) |=> o_pready; endproperty
    a_rdy_lat: assert property (p_rdy_lat)
        else $error("pready not one cycle after access");
    property p_idle; !i_psel |=> !o_pready [*2]; endproperty
    a_idle: assert property (p_idle)
        else $error("pready without a transfer");
    property p_err_rd; o_pready && o_pslverr && !i_pwrite |-> o_prdata == 32'h0; endproperty
    a_err_rd: assert property (p_err_rd)
        else $error("refused read returned data");
    property p_stat_wr; o_pready && i_pwrite && i_paddr == 12'h604 |-> o_pslverr; endproperty
    a_stat_wr: assert property (p_stat_wr)
        else $error("status write accepted");
    property p_iofb; $past(i_rst_n) |-> o_io_fb == $past(i_pin_in); endproperty
    a_iofb: assert property (p_iofb)
        else $error("pin feedback not one cycle late");
    property p_pull; (o_pin_oe & o_pin_pullup) == 16'h0; endproperty
    a_pull: assert property (p_pull)
        else $error("pull-up on a driven pin");
    property p_rst; $rose(i_rst_n) |-> o_pin_pullup == 16'hffff && o_mc_fb == 16'h0; endproperty
    a_rst: assert property (p_rst)
        else $error("wrong pad state after reset");
endmodule : plb_asserts

bind plb_logic_block plb_asserts u_chk (
    .i_sys_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .o_prdata,
    .o_pready, .o_pslverr, .i_pin_in, .o_pin_oe, .o_pin_pullup, .o_mc_fb, .o_io_fb
);

// ===== plb_pad_model.sv
// Purpose: Pad wires and outside drivers around the block.
// Assumes: Outside drive changes just after a rising edge.
// Notes:   An undriven pad without pull-up toggles every cycle.
`timescale 1ns/1ps
module plb_pad_model (
    // Clock and reset.
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    // Block drive.
    input  wire logic [15:0] i_out,
    input  wire logic [15:0] i_oe,
    input  wire logic [15:0] i_pull,
    // Outside drive.
    input  wire logic [15:0] i_ext,
    input  wire logic [15:0] i_ext_en,
    // Pad level.
    output logic      [15:0] o_pin
);
    logic [15:0] flt_q;
    ////////////////////////////////////////////////////////////////
    // A floating pad never repeats its last level, so no stale value passes.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flt_q <= 16'h0;
        end else begin
            flt_q <= ~flt_q;
        end
    end
    // Block drive wins, then the outside driver, then the weak pull-up.
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            o_pin[i] = i_oe[i] ? i_out[i] : i_ext_en[i] ? i_ext[i] : i_pull[i] | flt_q[i];
        end
    end
endmodule : plb_pad_model

// ===== plb_logic_block_tb.sv
// Purpose: Self-checking bench for the logic block.
// Assumes: APB answers come back in request order.
// Notes:   Two macrocells are set up; the others stay at reset.
`timescale 1ns/1ps
module plb_logic_block_tb;
    import plb_pkg::*;
    logic        i_sys_clk = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
    logic        i_pwrite = 1'b0, i_uclk = 1'b0, i_goe = 1'b0, o_pready, o_pslverr;
    logic [11:0] i_paddr = 12'h0;
    logic [31:0] i_pwdata = 32'h0, o_prdata;
    logic [35:0] i_xpt = 36'h0;
    logic [3:0]  i_clk_pin = 4'h0;
    logic [15:0] i_pin_in, o_pin_out, o_pin_oe, o_pin_pullup, o_pin_slow, o_mc_fb, o_io_fb;
    logic [15:0] ext = 16'h0, ext_en = 16'h0;
    logic [33:0] exp_q[$];
    logic [33:0] got;
    int          n_fail = 0;
    int          total_checks = 0;

    plb_logic_block i_dut (
        .i_sys_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .o_prdata, .o_pready, .o_pslverr, .i_xpt, .i_clk_pin, .i_uclk, .i_goe,
        .i_pin_in, .o_pin_out, .o_pin_oe, .o_pin_pullup, .o_pin_slow, .o_mc_fb, .o_io_fb
    );
    plb_pad_model i_pads (
        .i_sys_clk, .i_rst_n, .i_out(o_pin_out), .i_oe(o_pin_oe), .i_pull(o_pin_pullup),
        .i_ext(ext), .i_ext_en(ext_en), .o_pin(i_pin_in)
    );
    ////////////////////////////////////////////////////////////////
    // Free-running 10 MHz clock.
    initial begin
        forever #50 i_sys_clk = ~i_sys_clk;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : cyc

    // A clock pin pulse long enough for the sampled edge to be seen.
    task automatic pulse(input logic [3:0] p);
        i_clk_pin <= p;
        cyc(2);
        i_clk_pin <= 4'h0;
        cyc(4);
    endtask : pulse

    // One APB transfer; the expected answer is queued for the monitor.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic ee, input logic [31:0] ed);
        exp_q.push_back({w, ee, ed});
        i_psel   <= 1'b1;
        i_pwrite <= w;
        i_paddr  <= a;
        i_pwdata <= d;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_sys_clk);
        end while (o_pready !== 1'b1);
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_sys_clk);
    endtask : apb

    task automatic report_and_stop();
        if (exp_q.size() != 0) n_fail++;
        if (n_fail == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // Each answer is matched against the oldest queued note.
    always @(posedge i_sys_clk) begin
        if (o_pready === 1'b1) begin
            got = exp_q.pop_front();
            chk("pslverr", 32'(got[32]), 32'(o_pslverr));
            if (!got[33]) chk("prdata", got[31:0], o_prdata);
        end
    end

    // Hang guard, thirty times the run's length.
    initial begin
        cyc(3000);
        n_fail++;
        report_and_stop();
    end

    initial begin
        void'($urandom(32'h1b333f92));
        cyc(6);
        i_rst_n <= 1'b1;
        cyc(2);
        chk("io_fb", 32'hffff, 32'(o_io_fb));
        chk("oe", 32'h0, 32'(o_pin_oe));
        apb(1'b1, PT_BASE, 32'h1, 1'b0, 32'h0);
        apb(1'b1, PT_BASE + 12'h010, 32'h2, 1'b0, 32'h0);
        // Cell 0: combinational, driven, slow; table passes its own term.
        apb(1'b1, MC_BASE, 32'h0062_4002, 1'b0, 32'h0);
        // Cell 1: D register on global clock 0, starts at one, pad off.
        apb(1'b1, MC_BASE + 12'h008, 32'h0060_8020, 1'b0, 32'h0);
        apb(1'b0, STM_ADDR, 32'h0, 1'b0, 32'h2);
        apb(1'b1, GLB_ADDR, 32'h12, 1'b0, 32'h0);
        apb(1'b1, PT_BASE, 32'h5, 1'b1, 32'h0);
        apb(1'b0, PT_BASE, 32'h0, 1'b0, 32'h1);
        apb(1'b1, STM_ADDR, 32'h0, 1'b1, 32'h0);
        apb(1'b0, 12'h7fc, 32'h0, 1'b1, 32'h0);
        ext_en <= 16'hfffe;
        for (int i = 0; i < 6; i++) begin
            i_xpt <= 36'({$urandom, $urandom});
            ext   <= 16'($urandom);
            i_goe <= 1'($urandom);
            cyc(4);
            chk("mc_fb0", 32'(i_xpt[0]), 32'(o_mc_fb[0]));
            chk("pin0", 32'(i_xpt[0]), 32'(o_pin_out[0]));
            chk("io_fb", 32'({ext[15:1], i_xpt[0]}), 32'(o_io_fb));
        end
        chk("pads", 32'h5, 32'({o_pin_oe[1:0], o_pin_pullup[0], o_pin_slow[0]}));
        i_xpt <= 36'h0;
        cyc(2);
        pulse(4'h4);
        chk("mc_fb1", 32'h0, 32'(o_mc_fb[1]));
        i_xpt <= 36'h2;
        pulse(4'h2);
        chk("mc_fb1", 32'h0, 32'(o_mc_fb[1]));
        pulse(4'h4);
        chk("mc_fb1", 32'h1, 32'(o_mc_fb[1]));
        apb(1'b0, STM_ADDR, 32'h0, 1'b0, 32'h2);
        cyc(2);
        report_and_stop();
    end
endmodule : plb_logic_block_tb
